// ### design/uv_delay_timer.sv
// delay timer counting a power-of-two number of delay units
`timescale 1ns/1ps
`default_nettype none
module uv_delay_timer #(
    parameter int UNIT_W = 16,
    parameter int CODE_W = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [UNIT_W-1:0] unit_cycles,
    input wire logic [CODE_W-1:0] code,
    output logic done
);
    localparam int BLK_W = (1 << CODE_W);

    logic run_ff;
    logic done_ff;
    logic [UNIT_W-1:0] unit_cnt_ff;
    logic [BLK_W-1:0] blk_cnt_ff;
    logic [BLK_W-1:0] blk_last_ff;
    logic [UNIT_W-1:0] unit_last_ff;

    // a zero unit length is read as one cycle so the timer always ends
    wire [UNIT_W-1:0] unit_eff = (unit_cycles == '0) ?
        UNIT_W'(1) : unit_cycles;
    wire [BLK_W-1:0] blk_span = BLK_W'(1) << code;
    wire unit_tick = run_ff && (unit_cnt_ff == unit_last_ff);
    wire last_blk = unit_tick && (blk_cnt_ff == blk_last_ff);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            done_ff <= 1'b0;
            unit_cnt_ff <= '0;
            blk_cnt_ff <= '0;
            blk_last_ff <= '0;
            unit_last_ff <= '0;
        end else if (start) begin
            run_ff <= 1'b1;
            done_ff <= 1'b0;
            unit_cnt_ff <= '0;
            blk_cnt_ff <= '0;
            blk_last_ff <= blk_span - BLK_W'(1);
            unit_last_ff <= unit_eff - UNIT_W'(1);
        end else begin
            done_ff <= last_blk;
            run_ff <= run_ff && !last_blk;
            unit_cnt_ff <= unit_tick ? '0 : unit_cnt_ff + UNIT_W'(run_ff);
            blk_cnt_ff <= blk_cnt_ff + BLK_W'(unit_tick);
        end
    end

    assign done = done_ff;

    chk_timer_span: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (start && code == 3'h1 && unit_cycles == 16'h0003) ##1 (!start)[*7]
        |-> done && !$past(done))
        else $error("delay timer span is wrong");
endmodule
`default_nettype wire

// ### design/uv_fault_response.sv
// output undervoltage supervision with programmable fault response
`timescale 1ns/1ps
`default_nettype none
module uv_fault_response (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire logic [15:0] vout_meas,
    input wire logic [15:0] delay_unit_cycles,
    input wire logic output_cmd_on,
    input wire logic other_fault_off,
    output logic output_enable,
    output logic uv_warn,
    output logic uv_fault
);
    localparam int CHK_W = $clog2(uv_pkg::RESTART_CHECK_CYCLES + 1);
    localparam logic [CHK_W-1:0] CHK_LAST =
        CHK_W'(uv_pkg::RESTART_CHECK_CYCLES - 1);

    logic [15:0] warn_limit_ff;
    logic [15:0] fault_limit_ff;
    logic [7:0] action_ff;
    logic warn_ff;
    logic fault_ff;
    logic en_ff;
    logic cmd_on_d_ff;
    logic tmr_hit_ff;
    logic [2:0] att_ff;
    logic [CHK_W-1:0] chk_cnt_ff;
    logic [15:0] rd_data_ff;
    logic rd_valid_ff;
    uv_pkg::resp_state_t state_ff;
    uv_pkg::resp_state_t nxt_state;
    logic tmr_start;
    logic att_inc;
    logic att_clr;
    logic [15:0] rd_mux;
    logic warn_below;
    logic fault_below;
    logic tmr_done;

    // command decode
    wire wr_warn = cmd_wr && (cmd_code == uv_pkg::CMD_WARN_LIMIT);
    wire wr_fault = cmd_wr && (cmd_code == uv_pkg::CMD_FAULT_LIMIT);
    wire wr_action = cmd_wr && (cmd_code == uv_pkg::CMD_FAULT_ACTION);
    wire wr_status = cmd_wr && (cmd_code == uv_pkg::CMD_STATUS_VOUT);
    wire wr_clear = cmd_wr && (cmd_code == uv_pkg::CMD_CLEAR_FAULTS);

    // action byte fields
    wire [1:0] act_sel = action_ff[uv_pkg::ACT_HI:uv_pkg::ACT_LO];
    wire [2:0] retry_sel = action_ff[uv_pkg::RETRY_HI:uv_pkg::RETRY_LO];
    wire [2:0] delay_sel = action_ff[uv_pkg::DELAY_HI:uv_pkg::DELAY_LO];

    // an off-then-on command counts as a clear of the latched fault
    wire on_rise = output_cmd_on && !cmd_on_d_ff;
    wire clr_common = wr_clear || on_rise;
    wire clr_fault = clr_common ||
        (wr_status && cmd_wdata[uv_pkg::STAT_UV_FAULT_BIT]);
    wire clr_warn = clr_common ||
        (wr_status && cmd_wdata[uv_pkg::STAT_UV_WARN_BIT]);

    // ramp-up after a restart is not judged until the check window ends
    wire in_restart = (state_ff == uv_pkg::ST_RESTART);
    wire chk_done = in_restart && (chk_cnt_ff == CHK_LAST);
    wire judge = en_ff && (!in_restart || chk_done);
    wire fault_live = judge && fault_below;
    wire warn_evt = judge && warn_below;
    wire [2:0] att_next = att_ff + 3'h1;
    wire retry_spent = (retry_sel != uv_pkg::RETRY_CONT) &&
        (att_next >= retry_sel);
    wire nxt_en_state = (nxt_state == uv_pkg::ST_RUN) ||
        (nxt_state == uv_pkg::ST_RIDE) || (nxt_state == uv_pkg::ST_RESTART);

    uv_level_cmp #(.WIDTH(16)) u_warn_cmp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample(vout_meas),
        .limit(warn_limit_ff),
        .below(warn_below)
    );

    uv_level_cmp #(.WIDTH(16)) u_fault_cmp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample(vout_meas),
        .limit(fault_limit_ff),
        .below(fault_below)
    );

    // one timer serves both the ride-through delay and restart spacing
    uv_delay_timer #(.UNIT_W(16), .CODE_W(3)) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(tmr_start),
        .unit_cycles(delay_unit_cycles),
        .code(delay_sel),
        .done(tmr_done)
    );

    // a shutdown either latches off or begins the retry sequence
    wire shut_retry = (retry_sel != uv_pkg::RETRY_NONE);
    uv_pkg::resp_state_t shut_state;
    assign shut_state = shut_retry ? uv_pkg::ST_WAIT :
        uv_pkg::ST_LATCHED;

    always_comb begin
        nxt_state = state_ff;
        tmr_start = 1'b0;
        att_inc = 1'b0;
        att_clr = 1'b0;
        if (!output_cmd_on) begin
            nxt_state = uv_pkg::ST_RUN;
            att_clr = 1'b1;
        end else begin
            unique case (state_ff)
                uv_pkg::ST_RUN: begin
                    if (fault_live) begin
                        unique case (act_sel)
                            uv_pkg::ACT_IGNORE: begin
                                nxt_state = uv_pkg::ST_RUN;
                            end
                            uv_pkg::ACT_RIDE: begin
                                nxt_state = uv_pkg::ST_RIDE;
                                tmr_start = 1'b1;
                            end
                            uv_pkg::ACT_DISABLE: begin
                                nxt_state = shut_state;
                                tmr_start = shut_retry;
                            end
                            uv_pkg::ACT_HOLD: begin
                                nxt_state = uv_pkg::ST_HOLD;
                            end
                        endcase
                    end
                end
                uv_pkg::ST_RIDE: begin
                    if (!fault_below) begin
                        nxt_state = uv_pkg::ST_RUN;
                    end else if (tmr_done) begin
                        nxt_state = shut_state;
                        tmr_start = shut_retry;
                    end
                end
                uv_pkg::ST_HOLD: begin
                    if (!fault_below) begin
                        nxt_state = uv_pkg::ST_RUN;
                    end
                end
                uv_pkg::ST_WAIT: begin
                    if (other_fault_off) begin
                        nxt_state = uv_pkg::ST_LATCHED;
                    end else if (tmr_hit_ff || tmr_done) begin
                        nxt_state = uv_pkg::ST_RESTART;
                        tmr_start = 1'b1;
                    end
                end
                uv_pkg::ST_RESTART: begin
                    if (other_fault_off) begin
                        nxt_state = uv_pkg::ST_LATCHED;
                    end else if (chk_done && fault_below) begin
                        att_inc = 1'b1;
                        nxt_state = retry_spent ? uv_pkg::ST_LATCHED :
                            uv_pkg::ST_WAIT;
                    end else if (chk_done) begin
                        nxt_state = uv_pkg::ST_RUN;
                        att_clr = 1'b1;
                    end
                end
                uv_pkg::ST_LATCHED: begin
                    if (!fault_ff) begin
                        nxt_state = uv_pkg::ST_RUN;
                        att_clr = 1'b1;
                    end
                end
                default: begin
                    nxt_state = uv_pkg::ST_LATCHED;
                end
            endcase
        end
    end

    always_comb begin
        unique case (cmd_code)
            uv_pkg::CMD_WARN_LIMIT: rd_mux = warn_limit_ff;
            uv_pkg::CMD_FAULT_LIMIT: rd_mux = fault_limit_ff;
            uv_pkg::CMD_FAULT_ACTION: rd_mux = {8'h00, action_ff};
            uv_pkg::CMD_STATUS_VOUT: rd_mux =
                (16'(warn_ff) << uv_pkg::STAT_UV_WARN_BIT) |
                (16'(fault_ff) << uv_pkg::STAT_UV_FAULT_BIT);
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            warn_limit_ff <= uv_pkg::WARN_LIMIT_RST;
            fault_limit_ff <= uv_pkg::FAULT_LIMIT_RST;
            action_ff <= uv_pkg::FAULT_ACTION_RST;
        end else begin
            if (wr_warn) warn_limit_ff <= cmd_wdata;
            if (wr_fault) fault_limit_ff <= cmd_wdata;
            if (wr_action) action_ff <= cmd_wdata[7:0];
        end
    end

    // a new low event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            warn_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            warn_ff <= warn_evt || (warn_ff && !clr_warn);
            fault_ff <= fault_live || (fault_ff && !clr_fault);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= uv_pkg::ST_RUN;
            en_ff <= 1'b0;
            cmd_on_d_ff <= 1'b0;
            tmr_hit_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            en_ff <= output_cmd_on && nxt_en_state;
            cmd_on_d_ff <= output_cmd_on;
            tmr_hit_ff <= !tmr_start && (tmr_hit_ff || tmr_done);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            att_ff <= 3'h0;
            chk_cnt_ff <= '0;
        end else begin
            att_ff <= att_clr ? 3'h0 : (att_inc ? att_next : att_ff);
            chk_cnt_ff <= in_restart ? chk_cnt_ff + CHK_W'(1) : '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_ff <= 16'h0000;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= cmd_rd;
            if (cmd_rd) rd_data_ff <= rd_mux;
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign output_enable = en_ff;
    assign uv_warn = warn_ff;
    assign uv_fault = fault_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_run_fault(logic [1:0] act);
        state_ff == uv_pkg::ST_RUN && fault_live && output_cmd_on &&
            act_sel == act;
    endsequence

    sequence s_ride_expired;
        state_ff == uv_pkg::ST_RIDE && output_cmd_on && fault_below &&
            tmr_done;
    endsequence

    sequence s_write_warn;
        wr_warn && !cmd_rd ##1 !cmd_wr ##1 cmd_rd && !cmd_wr &&
            cmd_code == uv_pkg::CMD_WARN_LIMIT;
    endsequence

    chk_ignore_keeps_on: assert property (
        s_run_fault(uv_pkg::ACT_IGNORE) |=> output_enable)
        else $error("ignore action dropped the output");

    chk_ride_expiry_off: assert property (
        s_ride_expired |=> !output_enable)
        else $error("output still on after ride-through expired");

    chk_disable_at_once: assert property (
        s_run_fault(uv_pkg::ACT_DISABLE) |=> !output_enable)
        else $error("disable action left the output on");

    chk_hold_resume: assert property (
        state_ff == uv_pkg::ST_HOLD && !fault_below && output_cmd_on
        |=> output_enable && state_ff == uv_pkg::ST_RUN)
        else $error("hold action did not resume");

    chk_no_retry_latch: assert property (
        s_run_fault(uv_pkg::ACT_DISABLE) ##0 retry_sel == uv_pkg::RETRY_NONE
        |=> state_ff == uv_pkg::ST_LATCHED ##1 !output_enable)
        else $error("zero retries did not latch off");

    chk_once_limit: assert property (
        in_restart && chk_done && fault_below && output_cmd_on &&
        !other_fault_off && retry_sel == uv_pkg::RETRY_ONCE
        |=> state_ff == uv_pkg::ST_LATCHED)
        else $error("single retry did not latch off");

    chk_cont_retry: assert property (
        in_restart && chk_done && fault_below && output_cmd_on &&
        !other_fault_off && retry_sel == uv_pkg::RETRY_CONT
        |=> state_ff == uv_pkg::ST_WAIT)
        else $error("continuous retry stopped");

    chk_clear_faults: assert property (
        wr_clear && !fault_live |=> !uv_fault)
        else $error("clear command left the fault set");

    chk_latched_off: assert property (
        state_ff == uv_pkg::ST_LATCHED |-> !output_enable)
        else $error("output on while latched off");

    chk_cmd_off_stop: assert property (
        !output_cmd_on |=> !output_enable && state_ff == uv_pkg::ST_RUN)
        else $error("retry continued after off command");

    chk_warn_flag: assert property (
        warn_evt |=> uv_warn)
        else $error("warning flag not set");

    chk_warn_readback: assert property (
        s_write_warn |=> rd_valid && rd_data == $past(cmd_wdata, 3))
        else $error("warning threshold readback mismatch");
endmodule
`default_nettype wire

// ### design/uv_level_cmp.sv
// registered below-threshold comparator
`timescale 1ns/1ps
`default_nettype none
module uv_level_cmp #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] sample,
    input wire logic [WIDTH-1:0] limit,
    output logic below
);
    logic below_ff;
    wire is_below = sample < limit;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            below_ff <= 1'b0;
        end else begin
            below_ff <= is_below;
        end
    end

    assign below = below_ff;

    chk_below_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (sample < limit) |=> below)
        else $error("comparator missed a low sample");
endmodule
`default_nettype wire

// ### design/uv_pkg.sv
// constants and types for the output undervoltage fault response block
package uv_pkg;
    // command codes of the register port
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WARN_LIMIT = 8'h43;
    localparam logic [7:0] CMD_FAULT_LIMIT = 8'h44;
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h45;
    localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;

    // action byte layout
    localparam int ACT_HI = 7;
    localparam int ACT_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    // status byte layout
    localparam int STAT_UV_WARN_BIT = 5;
    localparam int STAT_UV_FAULT_BIT = 4;

    localparam logic [15:0] WARN_LIMIT_RST = 16'h0000;
    localparam logic [15:0] FAULT_LIMIT_RST = 16'h0000;
    localparam logic [7:0] FAULT_ACTION_RST = 8'h80;

    typedef enum logic [1:0] {
        ACT_IGNORE = 2'b00,
        ACT_RIDE = 2'b01,
        ACT_DISABLE = 2'b10,
        ACT_HOLD = 2'b11
    } action_t;

    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ONCE = 3'h1;
    localparam logic [2:0] RETRY_CONT = 3'h7;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_RIDE,
        ST_HOLD,
        ST_WAIT,
        ST_RESTART,
        ST_LATCHED
    } resp_state_t;

    localparam int CLK_PERIOD_NS = 10;
    // settle time after a restart before the output is judged good
    localparam int RESTART_CHECK_NS = 1000;
    localparam int RESTART_CHECK_CYCLES =
        (RESTART_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### verification/uv_fault_response_tb.sv
// self-checking bench for the undervoltage fault response block
`timescale 1ns/1ps
`default_nettype none
module uv_fault_response_tb;
    localparam logic [15:0] V_GOOD = 16'h8000;
    localparam logic [15:0] V_LOW = 16'h1000;
    localparam logic [15:0] L_WARN = 16'h6000;
    localparam logic [15:0] L_FAULT = 16'h4000;
    localparam int LIMIT = 40000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cmd_code;
    logic cmd_wr;
    logic cmd_rd;
    logic [15:0] cmd_wdata;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] vout_meas = 16'h8000;
    logic [15:0] delay_unit_cycles = 16'h0001;
    logic output_cmd_on = 1'b1;
    logic other_fault_off = 1'b0;
    logic output_enable;
    logic uv_warn;
    logic uv_fault;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rise_q[$];
    int tries [3] = '{0, 1, 3};
    logic oe_d = 1'b0;
    logic [7:0] codes [4];
    logic [15:0] shadow [logic [7:0]];

    always #5 sys_clk = ~sys_clk;

    uv_fault_response uv_fault_response_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_code(cmd_code),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .vout_meas(vout_meas),
        .delay_unit_cycles(delay_unit_cycles),
        .output_cmd_on(output_cmd_on), .other_fault_off(other_fault_off),
        .output_enable(output_enable), .uv_warn(uv_warn),
        .uv_fault(uv_fault)
    );

    uv_host_model uv_host_model_i (
        .sys_clk(sys_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    // restart starts are logged by cycle number for count and spacing
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        oe_d <= output_enable;
        if (output_enable === 1'b1 && oe_d === 1'b0) rise_q.push_back(cyc);
        if (cyc == LIMIT) begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] inr(input int v, input int lo,
                                        input int hi);
        return (v >= lo && v <= hi) ? 32'h0000_0001 : 32'h0000_0000;
    endfunction

    function automatic logic [15:0] act(input logic [1:0] a,
                                        input logic [2:0] r,
                                        input logic [2:0] c);
        return {8'h00, a, r, c};
    endfunction

    task automatic set_v(input logic [15:0] v);
        @(posedge sys_clk);
        vout_meas <= v;
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // cycles until output_enable shows val, -1 if it never does
    task automatic wait_oe(input logic val, input int max, output int n);
        n = -1;
        for (int i = 0; i < max; i++) begin
            @(negedge sys_clk);
            if (output_enable === val) begin
                n = i;
                break;
            end
        end
    endtask

    task automatic put(input logic [7:0] code, input logic [15:0] data);
        uv_host_model_i.wr(code, data);
        shadow[code] = (code == uv_pkg::CMD_FAULT_ACTION) ?
            {8'h00, data[7:0]} : data;
    endtask

    task automatic get_check(input logic [7:0] code);
        logic [15:0] d;
        uv_host_model_i.rd(code, d);
        check({16'h0000, d},
            {16'h0000, shadow.exists(code) ? shadow[code] : 16'h0000});
    endtask

    // good voltage, flags cleared, output back on, restart log emptied
    task automatic fresh();
        int n;
        set_v(V_GOOD);
        uv_host_model_i.clear_all();
        wait_oe(1'b1, 20, n);
        check(inr(n, 0, 19), 1);
        pause(2);
        rise_q.delete();
    endtask

    initial begin
        int n;
        int k;
        void'($urandom(32'h9ab3_11c4));
        codes = '{uv_pkg::CMD_WARN_LIMIT, uv_pkg::CMD_FAULT_LIMIT,
            uv_pkg::CMD_FAULT_ACTION, uv_pkg::CMD_STATUS_VOUT};
        shadow[codes[0]] = uv_pkg::WARN_LIMIT_RST;
        shadow[codes[1]] = uv_pkg::FAULT_LIMIT_RST;
        shadow[codes[2]] = {8'h00, uv_pkg::FAULT_ACTION_RST};
        shadow[codes[3]] = 16'h0000;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        wait_oe(1'b1, 4, n);
        check(inr(n, 0, 3), 1);
        foreach (codes[i]) get_check(codes[i]);
        get_check(8'h46);
        for (int i = 0; i < 3; i++) begin
            put(codes[i], 16'($urandom()));
            get_check(codes[i]);
        end
        uv_host_model_i.wr(8'h46, 16'hffff);
        get_check(8'h46);
        put(uv_pkg::CMD_WARN_LIMIT, L_WARN);
        put(uv_pkg::CMD_FAULT_LIMIT, L_FAULT);
        put(uv_pkg::CMD_FAULT_ACTION, act(2'b00, 3'd0, 3'd0));
        fresh();
        set_v(L_FAULT + 16'($urandom_range(8190)) + 16'h0001);
        pause(5);
        check({uv_warn, uv_fault, output_enable}, 3'b101);
        shadow[codes[3]] = 16'h0001 << uv_pkg::STAT_UV_WARN_BIT;
        get_check(codes[3]);
        set_v(V_GOOD);
        uv_host_model_i.wr(codes[3], shadow[codes[3]]);
        shadow[codes[3]] = 16'h0000;
        pause(3);
        check(uv_warn, 0);
        set_v(V_LOW);
        wait_oe(1'b0, 300, n);
        check(inr(n, -1, -1), 1);
        put(uv_pkg::CMD_FAULT_ACTION, act(2'b11, 3'd0, 3'd0));
        fresh();
        set_v(V_LOW);
        wait_oe(1'b0, 10, n);
        check(inr(n, 0, 9), 1);
        wait_oe(1'b1, 200, n);
        check(inr(n, -1, -1), 1);
        set_v(V_GOOD);
        wait_oe(1'b1, 10, n);
        check(inr(n, 0, 9), 1);
        @(posedge sys_clk);
        delay_unit_cycles <= 16'h0003;
        for (int c = 0; c < 8; c++) begin
            put(uv_pkg::CMD_FAULT_ACTION, act(2'b01, 3'd0, 3'(c)));
            fresh();
            set_v(V_LOW);
            wait_oe(1'b0, 400, n);
            check(inr(n, 3 << c, (3 << c) + 8), 1);
            set_v(V_GOOD);
            wait_oe(1'b1, 200, n);
            check(inr(n, -1, -1), 1);
        end
        // spacing of 160 cycles stays longer than the restart check window
        @(posedge sys_clk);
        delay_unit_cycles <= 16'h0028;
        foreach (tries[i]) begin
            put(uv_pkg::CMD_FAULT_ACTION, act(2'b10, 3'(tries[i]), 3'd2));
            fresh();
            set_v(V_LOW);
            wait_oe(1'b0, 6, n);
            check(inr(n, 0, 5), 1);
            pause(900);
            set_v(V_GOOD);
            pause(300);
            check(rise_q.size(), tries[i]);
            check(output_enable, 0);
            if (tries[i] == 3)
                check(inr(rise_q[2] - rise_q[1], 160, 166), 1);
            if (i == 0) uv_host_model_i.clear_all();
            if (i == 1)
                uv_host_model_i.wr(codes[3], 16'h0001 <<
                    uv_pkg::STAT_UV_FAULT_BIT);
            if (i == 2) begin
                @(posedge sys_clk);
                output_cmd_on <= 1'b0;
                pause(3);
                output_cmd_on <= 1'b1;
            end
            wait_oe(1'b1, 20, n);
            check(inr(n, 0, 19), 1);
        end
        @(posedge sys_clk);
        delay_unit_cycles <= 16'h0004;
        put(uv_pkg::CMD_FAULT_ACTION, act(2'b10, 3'd7, 3'd1));
        fresh();
        set_v(V_LOW);
        pause(1500);
        check(inr(rise_q.size(), 8, 100), 1);
        output_cmd_on <= 1'b0;
        wait_oe(1'b0, 5, n);
        check(inr(n, 0, 4), 1);
        k = rise_q.size();
        pause(400);
        check(rise_q.size(), k);
        output_cmd_on <= 1'b1;
        pause(30);
        other_fault_off <= 1'b1;
        pause(5);
        k = rise_q.size();
        pause(400);
        check({rise_q.size() - k, output_enable}, 0);
        other_fault_off <= 1'b0;
        fresh();
        // a reset in mid-run drops a latched fault and the written limits
        set_v(V_LOW);
        pause(5);
        check(uv_fault, 1);
        rst_n <= 1'b0;
        pause(2);
        rst_n <= 1'b1;
        wait_oe(1'b1, 4, n);
        check(inr(n, 0, 3), 1);
        check({uv_fault, uv_warn}, 0);
        shadow[codes[0]] = uv_pkg::WARN_LIMIT_RST;
        get_check(codes[0]);
        close_out();
    end
endmodule
`default_nettype wire

// ### verification/uv_host_model.sv
// host-side stand-in that drives the command port of the block
`timescale 1ns/1ps
`default_nettype none
module uv_host_model (
    input wire logic sys_clk,
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = 16'h0000;
    end

    // idle lines carry the inverse so a stale value never looks valid
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge sys_clk);
        cmd_code <= code;
        cmd_wdata <= data;
        cmd_wr <= 1'b1;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~data;
    endtask

    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        data = 'x;
        @(posedge sys_clk);
        cmd_code <= code;
        cmd_rd <= 1'b1;
        @(posedge sys_clk);
        cmd_rd <= 1'b0;
        cmd_code <= ~code;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            if (rd_valid === 1'b1) begin
                data = rd_data;
                break;
            end
        end
    endtask

    task automatic clear_all();
        wr(uv_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    endtask
endmodule
`default_nettype wire
